// *** sfa_bus_model.sv ***
// Wishbone classic master standing in for the decode and cycle control side
`timescale 1ns/10ps
`default_nettype none
module sfa_bus_model (
  input wire logic ref_clk,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [7:0] adr,
  output logic [3:0] sel,
  output logic [31:0] datOut,
  input wire logic ack,
  input wire logic [31:0] datIn,
  output logic hung
);
  // Idle bus from time zero
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    datOut = 32'h00000000;
    hung = 1'b0;
  end

  // One classic cycle; request held until ack is sampled, then released for a cycle
  task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    sel <= 4'hf;
    datOut <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    // A missing ack is flagged, the bench turns it into a failure
    if (ack !== 1'b1) hung = 1'b1;
    q = datIn;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** sfa_pkg.sv ***
// Shared constants, field layouts and types of the shift and fixed-point add unit
package sfa_pkg;
  // Machine cycle timing in clock pulses
  localparam logic [3:0] PULSE_LAST = 4'hb;
  localparam logic [3:0] PULSE_SC_LOAD = 4'h1;
  localparam logic [3:0] PULSE_END_TEST = 4'ha;
  localparam logic [3:0] PULSE_SR_LOAD = 4'h0;
  localparam logic [3:0] PULSE_SIGN_INV = 4'h1;
  localparam logic [7:0] SC_END_LIMIT = 8'h07;
  // Register byte offsets
  localparam logic [7:0] ADR_CMD = 8'h00;
  localparam logic [7:0] ADR_STAT = 8'h04;
  localparam logic [7:0] ADR_ACCH = 8'h08;
  localparam logic [7:0] ADR_ACCL = 8'h0c;
  localparam logic [7:0] ADR_MQH = 8'h10;
  localparam logic [7:0] ADR_MQL = 8'h14;
  localparam logic [7:0] ADR_SWH = 8'h18;
  localparam logic [7:0] ADR_SWL = 8'h1c;
  localparam logic [7:0] ADR_SC = 8'h20;
  localparam logic [7:0] ADR_SRH = 8'h24;
  localparam logic [7:0] ADR_SRL = 8'h28;
  // Command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_ADDR_LSB = 8;
  // Status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_OVF = 1;
  localparam int ST_QCARRY = 2;
  localparam int ST_ENDOP = 3;
  // Reset values
  localparam logic [7:0] SC_RESET = 8'h00;
  localparam logic [3:0] PULSE_RESET = 4'h0;
  localparam logic [14:0] ADDR_RESET = 15'h0000;

  typedef enum logic [3:0] {
    SFA_OP_NONE = 4'h0,
    SFA_OP_ALS = 4'h1,
    SFA_OP_LLS = 4'h2,
    SFA_OP_LGL = 4'h3,
    SFA_OP_ARS = 4'h4,
    SFA_OP_LRS = 4'h5,
    SFA_OP_LGR = 4'h6,
    SFA_OP_RQL = 4'h7,
    SFA_OP_CLA = 4'h8,
    SFA_OP_CLS = 4'h9,
    SFA_OP_CAL = 4'ha,
    SFA_OP_ADD = 4'hb
  } sfa_op_t;

  typedef enum logic [5:0] {
    SFA_IDLE = 6'h01,
    SFA_ICYC = 6'h02,
    SFA_LCYC = 6'h04,
    SFA_TAIL = 6'h08,
    SFA_ECYC = 6'h10,
    SFA_FCYC = 6'h20
  } sfa_state_t;

  // Sum register: sign, carry (Q), overflow (P), magnitude 1..35 (mag[34] is bit 1)
  typedef struct packed {
    logic sign;
    logic carry;
    logic ovfPos;
    logic [34:0] mag;
  } sfa_acc_t;

  // Plain signed word: quotient and storage word registers
  typedef struct packed {
    logic sign;
    logic [34:0] mag;
  } sfa_word_t;
endpackage

// *** sfa_shift_add_unit.sv ***
// Shift group and fixed-point load/add datapath with its cycle sequencer
// Notes on behaviour
// - Shift counter loads only the low eight address bits; at most 255 shifts.
// - From pulse 1 of the next extra cycle, shift and decrement each pulse.
// - First extra cycle gives at most eleven shifts, later ones twelve.
// - Counter seven or less at pulse ten ends; leftover shifts run in next fetch.
// - Bits leaving a register are lost; vacated places fill with zeros unless linked.
// - Sum-only left shift moves carry, overflow, 1-35; one into overflow sets indicator.
// - Long left chains quotient into sum bit 35; quotient sign copies to sum sign.
// - Logical long left also chains the quotient sign between bit 1 and sum 35.
// - Sum-only right shift fills carry with zero and drops bit 35.
// - Long right feeds sum 35 into quotient 1; sum sign copies to quotient.
// - Logical long right routes sum 35 to quotient sign, sign to quotient 1.
// - Quotient rotate left passes bit 1 to sign and sign to bit 35.
// - Clear-and-load fetches in execute cycle, loads sum in the following fetch.
// - Negated load inverts the storage word sign during the execute cycle.
// - Unsigned load puts word sign in overflow position, sum sign positive.
// - Like signs: add true magnitudes, keep the sum sign.
// - Unlike signs: add ones' complement of sum magnitude to storage magnitude.
// - Unlike signs: carry out of the carry position sets the carry-remember trigger.
// - End carry: add one, flip sign; no end carry: recomplement, keep sign.
// - Add fetches in execute cycle; adds and corrects in the following fetch.
`timescale 1ns/10ps
`default_nettype none
module sfa_shift_add_unit #(
  parameter int SC_WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic busy,
  output logic overflowInd
);
  logic [1:0] rstSync_r;
  logic rstN;
  logic ack_r;
  logic [31:0] rdData_r;
  logic wrFire;
  sfa_pkg::sfa_state_t state_r;
  sfa_pkg::sfa_op_t op_r;
  logic [14:0] addr_r;
  logic [3:0] pulse_r;
  logic firstL_r;
  logic endOp_r;
  logic [SC_WIDTH-1:0] sc_r;
  sfa_pkg::sfa_acc_t ac_r;
  sfa_pkg::sfa_acc_t acNxt;
  sfa_pkg::sfa_word_t mq_r;
  sfa_pkg::sfa_word_t mqNxt;
  sfa_pkg::sfa_word_t sr_r;
  sfa_pkg::sfa_word_t sw_r;
  logic ovf_r;
  logic ovfSet;
  logic qCarry_r;
  logic carrySet;
  logic shiftEn;
  logic isShift;
  logic cycEnd;
  logic cmdGo;

  // Reset release goes through two flops so every datapath flop leaves reset together
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync_r <= 2'h0;
    end else begin
      rstSync_r <= {rstSync_r[0], 1'b1};
    end
  end
  assign rstN = rstSync_r[1];

  // Byte lanes are ignored: every register is written as a whole word
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr[7:2] == off[7:2]);
  endfunction

  // Wishbone classic: ack one cycle after the strobe, write lands on the acked edge
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
    end
  end
  assign wb_ack_o = ack_r;
  assign wrFire = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;

  // Read data is captured in the request cycle; unmapped offsets read zero
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      rdData_r <= 32'h0;
    end else if (wb_cyc_i && wb_stb_i && !ack_r) begin
      rdData_r <= 32'h0;
      if (hit(wb_adr_i, sfa_pkg::ADR_CMD))
        rdData_r <= {9'h0, addr_r, 4'h0, op_r};
      if (hit(wb_adr_i, sfa_pkg::ADR_STAT))
        rdData_r <= {28'h0, endOp_r, qCarry_r, ovf_r, busy};
      if (hit(wb_adr_i, sfa_pkg::ADR_ACCH))
        rdData_r <= {26'h0, ac_r[37:32]};
      if (hit(wb_adr_i, sfa_pkg::ADR_ACCL))
        rdData_r <= ac_r.mag[31:0];
      if (hit(wb_adr_i, sfa_pkg::ADR_MQH))
        rdData_r <= {28'h0, mq_r[35:32]};
      if (hit(wb_adr_i, sfa_pkg::ADR_MQL))
        rdData_r <= mq_r.mag[31:0];
      if (hit(wb_adr_i, sfa_pkg::ADR_SWH))
        rdData_r <= {28'h0, sw_r[35:32]};
      if (hit(wb_adr_i, sfa_pkg::ADR_SWL))
        rdData_r <= sw_r.mag[31:0];
      if (hit(wb_adr_i, sfa_pkg::ADR_SC))
        rdData_r <= {{(32 - SC_WIDTH){1'b0}}, sc_r};
      if (hit(wb_adr_i, sfa_pkg::ADR_SRH))
        rdData_r <= {28'h0, sr_r[35:32]};
      if (hit(wb_adr_i, sfa_pkg::ADR_SRL))
        rdData_r <= sr_r.mag[31:0];
    end
  end
  assign wb_dat_o = rdData_r;

  // A command write is taken only while idle; while busy it is dropped
  assign cmdGo = wrFire && hit(wb_adr_i, sfa_pkg::ADR_CMD) && (state_r == sfa_pkg::SFA_IDLE);
  assign isShift = (op_r >= sfa_pkg::SFA_OP_ALS) && (op_r <= sfa_pkg::SFA_OP_RQL);
  assign cycEnd = (pulse_r == sfa_pkg::PULSE_LAST);
  assign busy = (state_r != sfa_pkg::SFA_IDLE);

  // Shift on every pulse of an extra cycle except pulse 0 of the first one
  assign shiftEn = (sc_r != '0) && (((state_r == sfa_pkg::SFA_LCYC)
                   && !(firstL_r && pulse_r == 4'h0))
                   || (state_r == sfa_pkg::SFA_TAIL));

  // Command capture
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      op_r <= sfa_pkg::SFA_OP_NONE;
      addr_r <= sfa_pkg::ADDR_RESET;
    end else if (cmdGo) begin
      op_r <= sfa_pkg::sfa_op_t'(wb_dat_i[sfa_pkg::CMD_OP_LSB +: 4]);
      addr_r <= wb_dat_i[sfa_pkg::CMD_ADDR_LSB +: 15];
    end
  end

  // Pulse counter numbers the twelve clock pulses of each machine cycle
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      pulse_r <= sfa_pkg::PULSE_RESET;
    end else if (cmdGo || cycEnd || state_r == sfa_pkg::SFA_IDLE) begin
      pulse_r <= sfa_pkg::PULSE_RESET;
    end else begin
      pulse_r <= pulse_r + 4'h1;
    end
  end

  // Cycle sequencer: fetch, then extra (shift) or execute cycles, then next fetch
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      state_r <= sfa_pkg::SFA_IDLE;
      firstL_r <= 1'b0;
      endOp_r <= 1'b0;
    end else begin
      case (state_r)
        sfa_pkg::SFA_IDLE: begin
          if (cmdGo) begin
            state_r <= sfa_pkg::SFA_ICYC;
            endOp_r <= 1'b0;
          end
        end
        sfa_pkg::SFA_ICYC: begin
          if (cycEnd) begin
            firstL_r <= 1'b1;
            if (!isShift)
              state_r <= sfa_pkg::SFA_ECYC;
            else if (sc_r == '0)
              state_r <= sfa_pkg::SFA_IDLE;
            else
              state_r <= sfa_pkg::SFA_LCYC;
          end
        end
        sfa_pkg::SFA_LCYC: begin
          if (pulse_r == sfa_pkg::PULSE_END_TEST && sc_r <= SC_WIDTH'(sfa_pkg::SC_END_LIMIT))
            endOp_r <= 1'b1;
          if (cycEnd) begin
            firstL_r <= 1'b0;
            if (endOp_r)
              state_r <= sfa_pkg::SFA_TAIL;
          end
        end
        sfa_pkg::SFA_TAIL: begin
          // Remaining shifts overlap the next fetch; at most five are left
          if (sc_r <= 1 || cycEnd)
            state_r <= sfa_pkg::SFA_IDLE;
        end
        sfa_pkg::SFA_ECYC: begin
          if (cycEnd)
            state_r <= sfa_pkg::SFA_FCYC;
        end
        sfa_pkg::SFA_FCYC: begin
          // Result lands on the first pulse of the next fetch cycle
          state_r <= sfa_pkg::SFA_IDLE;
          endOp_r <= 1'b1;
        end
        default: begin
          state_r <= sfa_pkg::SFA_IDLE;
        end
      endcase
    end
  end

  // Shift counter: loaded from the low address byte at pulse 1 of the fetch cycle
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      sc_r <= SC_WIDTH'(sfa_pkg::SC_RESET);
    end else if (state_r == sfa_pkg::SFA_ICYC && pulse_r == sfa_pkg::PULSE_SC_LOAD && isShift) begin
      sc_r <= addr_r[SC_WIDTH-1:0];
    end else if (shiftEn) begin
      sc_r <= sc_r - SC_WIDTH'(1);
    end
  end

  // Storage word register: taken from core storage, sign inverted for the negated load
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      sr_r <= '0;
    end else if (state_r == sfa_pkg::SFA_ECYC && pulse_r == sfa_pkg::PULSE_SR_LOAD) begin
      sr_r <= sw_r;
    end else if (state_r == sfa_pkg::SFA_ECYC && pulse_r == sfa_pkg::PULSE_SIGN_INV
                 && op_r == sfa_pkg::SFA_OP_CLS) begin
      sr_r.sign <= !sr_r.sign;
    end
  end

  // Core storage word as presented by software
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      sw_r <= '0;
    end else if (wrFire && hit(wb_adr_i, sfa_pkg::ADR_SWH)) begin
      sw_r[35:32] <= wb_dat_i[3:0];
    end else if (wrFire && hit(wb_adr_i, sfa_pkg::ADR_SWL)) begin
      sw_r.mag[31:0] <= wb_dat_i;
    end
  end

  // Shift network and sign-magnitude adder
  always_comb begin
    logic [36:0] acv;
    logic [37:0] sumLike;
    logic [37:0] sumComp;
    acv = {ac_r.carry, ac_r.ovfPos, ac_r.mag};
    sumLike = {1'b0, acv} + {3'h0, sr_r.mag};
    sumComp = {1'b0, ~acv} + {3'h0, sr_r.mag};
    acNxt = ac_r;
    mqNxt = mq_r;
    ovfSet = 1'b0;
    carrySet = 1'b0;
    if (shiftEn) begin
      case (op_r)
        sfa_pkg::SFA_OP_ALS: begin
          {acNxt.carry, acNxt.ovfPos, acNxt.mag} = {ac_r.ovfPos, ac_r.mag, 1'b0};
          ovfSet = ac_r.mag[34];
        end
        sfa_pkg::SFA_OP_LLS: begin
          {acNxt.carry, acNxt.ovfPos, acNxt.mag, mqNxt.mag} =
            {ac_r.ovfPos, ac_r.mag, mq_r.mag, 1'b0};
          acNxt.sign = mq_r.sign;
          ovfSet = ac_r.mag[34];
        end
        sfa_pkg::SFA_OP_LGL: begin
          {acNxt.carry, acNxt.ovfPos, acNxt.mag, mqNxt} =
            {ac_r.ovfPos, ac_r.mag, mq_r, 1'b0};
          ovfSet = ac_r.mag[34];
        end
        sfa_pkg::SFA_OP_ARS: begin
          {acNxt.carry, acNxt.ovfPos, acNxt.mag} = {1'b0, acv[36:1]};
        end
        sfa_pkg::SFA_OP_LRS: begin
          {acNxt.carry, acNxt.ovfPos, acNxt.mag, mqNxt.mag} =
            {1'b0, acv, mq_r.mag[34:1]};
          mqNxt.sign = ac_r.sign;
        end
        sfa_pkg::SFA_OP_LGR: begin
          {acNxt.carry, acNxt.ovfPos, acNxt.mag, mqNxt} = {1'b0, acv, mq_r[35:1]};
        end
        sfa_pkg::SFA_OP_RQL: begin
          mqNxt = {mq_r.mag, mq_r.sign};
        end
        default: begin
          acNxt = ac_r;
        end
      endcase
    end else if (state_r == sfa_pkg::SFA_FCYC) begin
      case (op_r)
        sfa_pkg::SFA_OP_CLA, sfa_pkg::SFA_OP_CLS: begin
          acNxt = {sr_r.sign, 2'h0, sr_r.mag};
        end
        sfa_pkg::SFA_OP_CAL: begin
          acNxt = {1'b0, 1'b0, sr_r.sign, sr_r.mag};
        end
        sfa_pkg::SFA_OP_ADD: begin
          if (ac_r.sign == sr_r.sign) begin
            {acNxt.carry, acNxt.ovfPos, acNxt.mag} = sumLike[36:0];
          end else begin
            carrySet = sumComp[37];
            if (sumComp[37]) begin
              {acNxt.carry, acNxt.ovfPos, acNxt.mag} = sumComp[36:0] + 37'h1;
              acNxt.sign = !ac_r.sign;
            end else begin
              {acNxt.carry, acNxt.ovfPos, acNxt.mag} = ~sumComp[36:0];
            end
          end
        end
        default: begin
          acNxt = ac_r;
        end
      endcase
    end
  end

  // Sum and quotient registers; software may load them only while idle
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      ac_r <= '0;
      mq_r <= '0;
    end else if (busy) begin
      ac_r <= acNxt;
      mq_r <= mqNxt;
    end else if (wrFire) begin
      if (hit(wb_adr_i, sfa_pkg::ADR_ACCH))
        ac_r[37:32] <= wb_dat_i[5:0];
      if (hit(wb_adr_i, sfa_pkg::ADR_ACCL))
        ac_r.mag[31:0] <= wb_dat_i;
      if (hit(wb_adr_i, sfa_pkg::ADR_MQH))
        mq_r[35:32] <= wb_dat_i[3:0];
      if (hit(wb_adr_i, sfa_pkg::ADR_MQL))
        mq_r.mag[31:0] <= wb_dat_i;
    end
  end

  // Sticky overflow indicator, a hardware set in the clearing cycle wins over the clear; carry trigger reloads on every add
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      ovf_r <= 1'b0;
      qCarry_r <= 1'b0;
    end else begin
      if (ovfSet)
        ovf_r <= 1'b1;
      else if (wrFire && hit(wb_adr_i, sfa_pkg::ADR_STAT) && wb_dat_i[sfa_pkg::ST_OVF])
        ovf_r <= 1'b0;
      if (state_r == sfa_pkg::SFA_FCYC && op_r == sfa_pkg::SFA_OP_ADD)
        qCarry_r <= carrySet;
    end
  end
  assign overflowInd = ovf_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstN);

  sequence scLoadSeq;
    state_r == sfa_pkg::SFA_ICYC && pulse_r == sfa_pkg::PULSE_SC_LOAD && isShift;
  endsequence
  sequence zeroEndSeq;
    state_r == sfa_pkg::SFA_ICYC && cycEnd && isShift && sc_r == '0;
  endsequence

  sc_load_a: assert property (scLoadSeq |=> sc_r == $past(addr_r[7:0]))
    else $error("shift counter not loaded from address low byte");
  sc_step_a: assert property (shiftEn |=> sc_r == $past(sc_r) - SC_WIDTH'(1))
    else $error("shift counter did not step down");
  first_pulse_a: assert property (state_r == sfa_pkg::SFA_LCYC && firstL_r
    && pulse_r == 4'h0 |-> !shiftEn)
    else $error("shift on pulse 0 of first extra cycle");
  end_test_a: assert property (state_r == sfa_pkg::SFA_LCYC && pulse_r == 4'ha
    && sc_r <= 7 |=> endOp_r ##1 state_r == sfa_pkg::SFA_TAIL)
    else $error("end of operation missed");
  left_fill_a: assert property (shiftEn && op_r == sfa_pkg::SFA_OP_ALS
    |=> ac_r.mag[0] == 1'b0 && ac_r.carry == $past(ac_r.ovfPos))
    else $error("left shift fill wrong");
  long_left_a: assert property (shiftEn && op_r == sfa_pkg::SFA_OP_LLS
    |=> ac_r.mag[0] == $past(mq_r.mag[34]) && ac_r.sign == $past(mq_r.sign))
    else $error("long left link wrong");
  long_right_a: assert property (shiftEn && op_r == sfa_pkg::SFA_OP_LRS
    |=> mq_r.mag[34] == $past(ac_r.mag[0]) && mq_r.sign == $past(ac_r.sign))
    else $error("long right link wrong");
  rotate_mq_a: assert property (shiftEn && op_r == sfa_pkg::SFA_OP_RQL
    |=> mq_r == {$past(mq_r.mag), $past(mq_r.sign)})
    else $error("quotient rotate lost a bit");
  zero_count_a: assert property (zeroEndSeq |=> state_r == sfa_pkg::SFA_IDLE
    && $stable(ac_r) && $stable(mq_r))
    else $error("zero count altered registers");
  load_sum_a: assert property (state_r == sfa_pkg::SFA_FCYC && op_r == sfa_pkg::SFA_OP_CLA
    |=> ac_r == {$past(sr_r.sign), 2'h0, $past(sr_r.mag)})
    else $error("clear and load result wrong");
endmodule
`default_nettype wire

// *** sfa_tb.sv ***
// Self-checking bench for the shift and fixed-point add unit
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc, stb, we, ack, busy, overflowInd, hung, ov, cr;
  logic [7:0] adr, cnt;
  logic [3:0] sel;
  logic [14:0] ad;
  logic [31:0] wdat, rdat, d, r1, r2, r3, r4, r5;
  logic [15:0] seed = 16'hc5b5;
  int fails = 0;
  int total_checks = 0;
  sfa_pkg::sfa_op_t op;
  sfa_pkg::sfa_acc_t a, ga;
  sfa_pkg::sfa_word_t q, gq, w;

  always #5 ref_clk = ~ref_clk;

  sfa_shift_add_unit #(.SC_WIDTH(8)) i_sfa_shift_add_unit (.ref_clk(ref_clk), .rst_n(rst_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .busy(busy),
    .overflowInd(overflowInd));

  sfa_bus_model i_sfa_bus_model (.ref_clk(ref_clk), .cyc(cyc), .stb(stb), .we(we),
    .adr(adr), .sel(sel), .datOut(wdat), .ack(ack), .datIn(rdat), .hung(hung));

  // Repeatable pseudo-random source
  function automatic void rnd(output logic [31:0] r);
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    r[15:0] = seed;
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    r[31:16] = seed;
  endfunction

  task automatic check(input string what, input logic [37:0] exp, input logic [37:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report();
    if (hung === 1'b1) fails++;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a8, input logic [31:0] dv);
    logic [31:0] x;
    i_sfa_bus_model.access(1'b1, a8, dv, x);
  endtask

  task automatic rd(input logic [7:0] a8, output logic [31:0] x);
    i_sfa_bus_model.access(1'b0, a8, 32'h00000000, x);
  endtask

  task automatic put_regs(input sfa_pkg::sfa_acc_t av, input sfa_pkg::sfa_word_t qv);
    wr(sfa_pkg::ADR_ACCH, {26'h0, av[37:32]});
    wr(sfa_pkg::ADR_ACCL, av[31:0]);
    wr(sfa_pkg::ADR_MQH, {28'h0, qv[35:32]});
    wr(sfa_pkg::ADR_MQL, qv[31:0]);
  endtask

  task automatic get_regs(output sfa_pkg::sfa_acc_t av, output sfa_pkg::sfa_word_t qv);
    logic [31:0] h, l, mh, ml;
    rd(sfa_pkg::ADR_ACCH, h);
    rd(sfa_pkg::ADR_ACCL, l);
    rd(sfa_pkg::ADR_MQH, mh);
    rd(sfa_pkg::ADR_MQL, ml);
    av = {h[5:0], l};
    qv = {mh[3:0], ml};
  endtask

  // Busy is polled with a bound so a stuck sequencer cannot hang the run
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (busy !== 1'b0 && n < 5000);
    if (n >= 5000) begin
      fails++;
      final_report();
    end
  endtask

  task automatic run(input logic [3:0] o, input logic [14:0] av);
    wr(sfa_pkg::ADR_CMD, {9'h000, av, 4'h0, o});
    wait_idle();
  endtask

  // Expected registers after n single-place shifts
  function automatic void shift_model(input sfa_pkg::sfa_op_t o, input int n,
      inout sfa_pkg::sfa_acc_t x, inout sfa_pkg::sfa_word_t y, inout logic v);
    for (int i = 0; i < n; i++) begin
      case (o)
        sfa_pkg::SFA_OP_ALS: {x.carry, x.ovfPos, x.mag} = {x.ovfPos, x.mag, 1'b0};
        sfa_pkg::SFA_OP_LLS: begin
          {x.carry, x.ovfPos, x.mag, y.mag} = {x.ovfPos, x.mag, y.mag, 1'b0};
          x.sign = y.sign;
        end
        sfa_pkg::SFA_OP_LGL:
          {x.carry, x.ovfPos, x.mag, y.sign, y.mag} = {x.ovfPos, x.mag, y.sign, y.mag, 1'b0};
        sfa_pkg::SFA_OP_ARS: {x.carry, x.ovfPos, x.mag} = {1'b0, x.carry, x.ovfPos, x.mag[34:1]};
        sfa_pkg::SFA_OP_LRS: begin
          {x.carry, x.ovfPos, x.mag, y.mag} = {1'b0, x.carry, x.ovfPos, x.mag, y.mag[34:1]};
          y.sign = x.sign;
        end
        sfa_pkg::SFA_OP_LGR: {x.carry, x.ovfPos, x.mag, y.sign, y.mag} =
          {1'b0, x.carry, x.ovfPos, x.mag, y.sign, y.mag[34:1]};
        default: y = {y.mag, y.sign};
      endcase
      // Only left shifts set the indicator when a one enters the overflow place
      if (o < sfa_pkg::SFA_OP_ARS) v = v | x.ovfPos;
    end
  endfunction

  // Expected sum register after a load or add; operands kept below 2**34
  function automatic sfa_pkg::sfa_acc_t load_model(input sfa_pkg::sfa_op_t o,
      input sfa_pkg::sfa_acc_t x, input sfa_pkg::sfa_word_t y, output logic c);
    logic [35:0] s;
    c = 1'b0;
    s = {1'b0, ~x.mag} + {1'b0, y.mag};
    case (o)
      sfa_pkg::SFA_OP_CLA: return {y.sign, 2'b00, y.mag};
      sfa_pkg::SFA_OP_CLS: return {~y.sign, 2'b00, y.mag};
      sfa_pkg::SFA_OP_CAL: return {2'b00, y.sign, y.mag};
      default: begin
        if (x.sign == y.sign) return {x.sign, 2'b00, x.mag + y.mag};
        c = s[35];
        if (c) return {~x.sign, 2'b00, y.mag - x.mag};
        return {x.sign, 2'b00, x.mag - y.mag};
      end
    endcase
  endfunction

  initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(sfa_pkg::ADR_ACCH, d);
    check("sum high after reset", 38'h0, {6'h0, d});
    rd(8'hfc, d);
    check("unmapped read", 38'h0, {6'h0, d});
    $display("test reset done");
    // Every shift op against zero, full, first/later cycle boundary and random counts
    for (int k = 0; k < 28; k++) begin
      rnd(r1);
      rnd(r2);
      rnd(r3);
      rnd(r4);
      rnd(r5);
      op = sfa_pkg::sfa_op_t'(4'h1 + 4'(k % 7));
      if (k < 7) cnt = 8'h00;
      else if (k < 14) cnt = 8'hff;
      else if (k < 21) cnt = 8'(k - 7);
      else cnt = {2'b00, r5[5:0]};
      ad = {r5[14:8], cnt};
      a = {r1[5:0], r2};
      q = {r3[3:0], r4};
      wr(sfa_pkg::ADR_STAT, 32'h00000002);
      put_regs(a, q);
      ov = 1'b0;
      shift_model(op, int'(ad[7:0]), a, q, ov);
      run(op, ad);
      get_regs(ga, gq);
      check("sum reg", a, ga);
      check("quotient reg", {2'b00, q}, {2'b00, gq});
      check("overflow", {37'h0, ov}, {37'h0, overflowInd});
      rd(sfa_pkg::ADR_SC, d);
      check("shift counter", 38'h0, {6'h0, d});
    end
    $display("test shifts done");
    // Loads and adds, with an equal-magnitude unlike-sign case
    for (int k = 0; k < 16; k++) begin
      rnd(r1);
      rnd(r2);
      rnd(r3);
      rnd(r4);
      op = sfa_pkg::sfa_op_t'(4'h8 + 4'(k % 4));
      a = {r1[5], 3'b000, r1[1:0], r2};
      w = {r3[3], 1'b0, r3[1:0], r4};
      if (k == 7) w = {~a.sign, a.mag};
      wr(sfa_pkg::ADR_SWH, {28'h0, w[35:32]});
      wr(sfa_pkg::ADR_SWL, w[31:0]);
      put_regs(a, {r4[3:0], r3});
      run(op, r2[14:0]);
      get_regs(ga, gq);
      check("load or add", load_model(op, a, w, cr), ga);
      rd(sfa_pkg::ADR_STAT, d);
      if (op == sfa_pkg::SFA_OP_ADD) check("carry trigger", {37'h0, cr}, {37'h0, d[2]});
      check("end op", 38'h1, {37'h0, d[3]});
      rd(sfa_pkg::ADR_SRH, d);
      check("storage reg", {34'h0, w.sign ^ (op == sfa_pkg::SFA_OP_CLS), w.mag[34:32]},
        {34'h0, d[3:0]});
    end
    $display("test load add done");
    // Writes while busy must be ignored
    rnd(r1);
    rnd(r2);
    a = {r1[5:0], r2};
    q = {r2[3:0], r1};
    wr(sfa_pkg::ADR_STAT, 32'h00000002);
    put_regs(a, q);
    ov = 1'b0;
    shift_model(sfa_pkg::SFA_OP_LLS, 60, a, q, ov);
    wr(sfa_pkg::ADR_CMD, {9'h000, 15'h003c, 4'h0, 4'h2});
    wr(sfa_pkg::ADR_ACCL, 32'h00000000);
    wr(sfa_pkg::ADR_CMD, {9'h000, 15'h0005, 4'h0, 4'h4});
    wait_idle();
    get_regs(ga, gq);
    check("busy sum reg", a, ga);
    check("busy quotient reg", {2'b00, q}, {2'b00, gq});
    wr(sfa_pkg::ADR_STAT, 32'h00000002);
    // The clear lands on the acked edge; look one edge later, once it has settled
    @(posedge ref_clk);
    check("overflow cleared", 38'h0, {37'h0, overflowInd});
    $display("test busy refusal done");
    final_report();
  end
endmodule
`default_nettype wire
